// File: hdl/cmd_list_mem.sv
// Command-list memory of 256 bytes with registered read port
`timescale 1ns/100ps
module cmd_list_mem
  import nvm_loader_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int IW    = 8
)
(
  // Clock
  input  wire logic          mclk_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [IW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // Read port
  input  wire logic [IW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);

  logic [7:0] mem_q [DEPTH];

  // Default list: transfer every byte once, apply, end of data.
  // Entries of 128 bytes cover the whole space in 32 commands.
  function automatic logic [7:0] default_byte(input int idx);
    int ent;
    ent = idx / 3;
    if (idx >= 96)
      return (idx == 96) ? {1'b1, OP_APPLY_STAGED} : {1'b1, OP_END_OF_DATA};
    unique case (idx % 3)
      0:       return 8'h7f;
      1:       return 8'(ent >> 1);
      default: return 8'((ent & 1) << 7);
    endcase
  endfunction : default_byte

  // Array initialised from the default list; no reset for memory
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      mem_q[i] = default_byte(i);
  end

  // Write port; plain always since the initial image also fills the array
  always @(posedge mclk_i)
  begin
    if (we_i)
      mem_q[waddr_i] <= wdata_i;
  end

  // Registered read
  always_ff @(posedge mclk_i)
  begin
    rdata_o <= mem_q[raddr_i];
  end

endmodule : cmd_list_mem

// File: hdl/gap_timer.sv
// Timer enforcing the least gap between transfers
`timescale 1ns/100ps
module gap_timer
  import nvm_loader_pkg::*;
#(
  parameter int CYCLES = GAP_CYCLES
)
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic start_i,
  output logic      busy_o
);

  logic [15:0] cnt_q;

  // Reload on start, count down to zero
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_q <= 16'h0000;
    else if (start_i)
      cnt_q <= 16'(CYCLES);
    else if (cnt_q != 16'h0000)
      cnt_q <= cnt_q - 16'h0001;
  end

  assign busy_o = (cnt_q != 16'h0000);

endmodule : gap_timer

// File: hdl/nvm_loader.sv
// Staged-register commit and command-list interpreter for nonvolatile storage
`timescale 1ns/100ps
module nvm_loader
  import nvm_loader_pkg::*;
#(
  parameter int GAP = GAP_CYCLES
)
(
  // Clock and reset (mclk is the serial port clock)
  input  wire logic          mclk_i,
  input  wire logic          resetn_i,
  // Serial port register access
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  input  wire logic [AW-1:0] reg_addr_i,
  input  wire logic [DW-1:0] reg_wdata_i,
  output logic      [DW-1:0] reg_rdata_o,
  // Register space for staged/active copy and nvm moves
  output logic               commit_o,
  output logic               rs_rd_o,
  output logic               rs_wr_o,
  output logic      [AW-1:0] rs_addr_o,
  output logic      [DW-1:0] rs_wdata_o,
  input  wire logic [DW-1:0] rs_rdata_i,
  // Nonvolatile memory port
  output logic               nvm_wr_o,
  output logic               nvm_rd_o,
  output logic      [AW-1:0] nvm_addr_o,
  output logic      [DW-1:0] nvm_wdata_o,
  input  wire logic [DW-1:0] nvm_rdata_i,
  input  wire logic          nvm_ack_i,
  input  wire logic          nvm_err_i,
  // Restore request from power-up or pin
  input  wire logic          restore_req_i,
  // Transfer status
  output logic               busy_o
);

  loader_state_t state_q, state_d;
  logic [7:0]    ptr_q, ptr_d;
  logic [6:0]    len_q, len_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [AW-1:0] naddr_q, naddr_d;
  logic          store_q, store_d;
  logic          commit_q, commit_d;
  logic          trig_q, trig_d;
  logic          err_q, err_d;
  logic          wen_q, wen_d;
  logic          soft_q, soft_d;
  logic          step_q, step_d;
  logic [7:0]    mem_rdata;
  logic          gap_busy;

  // Address decode
  wire hit_commit = reg_addr_i == COMMIT_ADDR;
  wire hit_list   = reg_addr_i >= LIST_BASE && reg_addr_i <= LIST_LAST;
  wire hit_stat   = reg_addr_i == XFER_STAT_ADDR;
  wire hit_err    = reg_addr_i == XFER_ERR_ADDR;
  wire hit_ctrl   = reg_addr_i == NVM_CTRL_ADDR;
  wire hit_trig   = reg_addr_i == STORE_TRIG_ADDR;
  wire idle       = state_q == ST_IDLE;
  wire list_we    = reg_wr_i && hit_list && idle;    // List locked while walking
  wire [7:0] list_raddr = idle ? reg_addr_i[7:0] : ptr_d;
  wire start_store = reg_wr_i && hit_trig && reg_wdata_i[STORE_TRIG_BIT] && wen_q;
  wire start_load  = restore_req_i || (reg_wr_i && hit_ctrl && reg_wdata_i[SOFT_LOAD_BIT]);
  wire start_ok    = idle && !gap_busy;
  wire cmd_is_op   = mem_rdata[OPCODE_BIT];
  wire done_pulse  = state_q == ST_DONE;

  cmd_list_mem u_mem
  (
    .mclk_i  (mclk_i),
    .we_i    (list_we),
    .waddr_i (reg_addr_i[7:0]),
    .wdata_i (reg_wdata_i),
    .raddr_i (list_raddr),
    .rdata_o (mem_rdata)
  );

  // spacing between transfers kept by device too
  gap_timer #(.CYCLES(GAP)) u_gap
  (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (done_pulse),
    .busy_o   (gap_busy)
  );

  // Command-list walker
  always_comb
  begin
    state_d  = state_q;
    ptr_d    = ptr_q;
    len_d    = len_q;
    addr_d   = addr_q;
    naddr_d  = naddr_q;
    store_d  = store_q;
    step_d   = 1'b0;
    err_d    = err_q;
    commit_d = 1'b0;
    trig_d   = trig_q;
    rs_rd_o  = 1'b0;
    rs_wr_o  = 1'b0;
    nvm_wr_o = 1'b0;
    nvm_rd_o = 1'b0;
    if (reg_wr_i && hit_commit && reg_wdata_i[COMMIT_BIT])
      commit_d = 1'b1;
    unique case (state_q)
      ST_IDLE:
      begin
        if ((start_store || start_load) && start_ok)
        begin
          state_d = ST_CMD;
          ptr_d   = 8'h00;
          naddr_d = '0;
          store_d = start_store;
          err_d   = 1'b0;
          // trigger set only by accepted store
          trig_d  = start_store;
        end
      end
      ST_CMD:
      begin
        if (!step_q)
          step_d = 1'b1;                     // Wait one cycle for read data
        else if (cmd_is_op)
        begin
          if (mem_rdata[6:0] == OP_APPLY_STAGED)
          begin
            commit_d = 1'b1;
            ptr_d    = ptr_q + 8'h01;
          end
          else if (mem_rdata[6:0] == OP_END_OF_DATA)
            state_d = ST_DONE;
          else
          begin
            err_d   = 1'b1;
            state_d = ST_DONE;
          end
        end
        else
        begin
          len_d   = mem_rdata[6:0];
          ptr_d   = ptr_q + 8'h01;
          state_d = ST_ADRH;
        end
        // running off the end is treated as error
        if (step_q && ptr_q == 8'hff && !(cmd_is_op && mem_rdata[6:0] == OP_END_OF_DATA))
        begin
          err_d   = 1'b1;
          state_d = ST_DONE;
        end
      end
      ST_ADRH:
      begin
        if (!step_q)
          step_d = 1'b1;
        else
        begin
          addr_d[AW-1:8] = mem_rdata[AW-9:0];
          ptr_d   = ptr_q + 8'h01;
          state_d = ST_ADRL;
        end
      end
      ST_ADRL:
      begin
        if (!step_q)
          step_d = 1'b1;
        else
        begin
          addr_d[7:0] = mem_rdata;
          ptr_d   = ptr_q + 8'h01;
          state_d = ST_DATA;
        end
      end
      ST_DATA:
      begin
        // One byte per acknowledged nvm access; a quiet cycle first
        // lets the registered store data catch up with the address
        rs_rd_o = store_q;
        if (!step_q)
          step_d = 1'b1;
        else
        begin
          step_d   = !nvm_ack_i;
          rs_wr_o  = !store_q && nvm_ack_i;
          nvm_wr_o = store_q;
          nvm_rd_o = !store_q;
          if (nvm_ack_i)
          begin
            if (nvm_err_i)
              err_d = 1'b1;
            addr_d  = addr_q + 12'h001;
            naddr_d = naddr_q + 12'h001;
            len_d   = len_q - 7'h01;
            if (len_q == 7'h00)
              state_d = ST_CMD;
          end
        end
      end
      ST_DONE:
      begin
        trig_d  = 1'b0;
        state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  // State and walker registers
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      ptr_q   <= 8'h00;
      len_q   <= 7'h00;
      addr_q  <= 12'h000;
      naddr_q <= 12'h000;
      store_q <= 1'b0;
      step_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q   <= ptr_d;
      len_q   <= len_d;
      addr_q  <= addr_d;
      naddr_q <= naddr_d;
      store_q <= store_d;
      step_q  <= step_d;
    end
  end

  // Control and status flags
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      commit_q <= 1'b0;
      trig_q   <= 1'b0;
      err_q    <= 1'b0;
      wen_q    <= 1'b0;
      soft_q   <= 1'b0;
    end
    else
    begin
      commit_q <= commit_d;
      trig_q   <= trig_d;
      err_q    <= err_d;
      wen_q    <= wen_d;
      soft_q   <= soft_d;
    end
  end

  // Write-enable bit; soft-load bit self-clears next cycle
  assign wen_d  = (reg_wr_i && hit_ctrl) ? reg_wdata_i[WR_ENABLE_BIT] : wen_q;
  assign soft_d = reg_wr_i && hit_ctrl && reg_wdata_i[SOFT_LOAD_BIT];

  // Data path: store reads register space, restore reads nvm
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      nvm_wdata_o <= REG_RESET;
    else
      nvm_wdata_o <= rs_rdata_i;
  end

  assign rs_wdata_o = nvm_rdata_i;
  assign rs_addr_o  = addr_q;
  assign nvm_addr_o = naddr_q;
  assign commit_o   = commit_q;
  assign busy_o     = !idle;

  // default list image lives in the memory
  // Read mux; list entries are not muxed and read back as zero
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= REG_RESET;
    else if (reg_rd_i)
      reg_rdata_o <= hit_stat   ? {7'h00, !idle} :
                     hit_err    ? {7'h00, err_q} :
                     hit_ctrl   ? {6'h00, soft_q, wen_q} :
                     hit_trig   ? {7'h00, trig_q} :
                     hit_commit ? {7'h00, commit_q} :
                     REG_RESET;
  end

endmodule : nvm_loader

// File: include/nvm_loader_pkg.sv
// Constants and types shared by the command-list loader design
package nvm_loader_pkg;

  // Register offsets in the serial port address space
  localparam logic [11:0] COMMIT_ADDR     = 12'h232;
  localparam logic [11:0] LIST_BASE       = 12'ha00;
  localparam logic [11:0] LIST_LAST       = 12'haff;
  localparam logic [11:0] XFER_STAT_ADDR  = 12'hb00;
  localparam logic [11:0] XFER_ERR_ADDR   = 12'hb01;
  localparam logic [11:0] NVM_CTRL_ADDR   = 12'hb02;
  localparam logic [11:0] STORE_TRIG_ADDR = 12'hb03;

  // Field positions
  localparam int COMMIT_BIT     = 0;
  localparam int STORE_TRIG_BIT = 0;
  localparam int WR_ENABLE_BIT  = 0;
  localparam int SOFT_LOAD_BIT  = 1;
  localparam int OPCODE_BIT     = 7;

  // Opcode encodings (low seven bits of an opcode entry)
  localparam logic [6:0] OP_APPLY_STAGED = 7'h00;
  localparam logic [6:0] OP_END_OF_DATA  = 7'h7f;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Address and data width of the register space
  localparam int AW = 12;
  localparam int DW = 8;

  // Least gap between two transfers
  localparam int  GAP_TIME_NS   = 10000;
  localparam int  CLK_PERIOD_NS = 4;
  localparam int  GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller states
  typedef enum logic [6:0]
  {
    ST_IDLE = 7'b0000001,
    ST_CMD  = 7'b0000010,
    ST_ADRH = 7'b0000100,
    ST_ADRL = 7'b0001000,
    ST_DATA = 7'b0010000,
    ST_DONE = 7'b0100000,
    ST_ERR  = 7'b1000000
  } loader_state_t;

endpackage : nvm_loader_pkg

// File: verification/nvm_loader_chk.sv
// Port assertions for the command-list loader
`timescale 1ns/100ps
module nvm_loader_chk
  import nvm_loader_pkg::*;
(
  // Clock, reset and host port
  input wire logic          mclk_i,
  input wire logic          resetn_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [DW-1:0] reg_wdata_i,
  input wire logic [DW-1:0] reg_rdata_o,
  // Loader outputs and nvm handshake
  input wire logic          commit_o,
  input wire logic          rs_rd_o,
  input wire logic          rs_wr_o,
  input wire logic          nvm_wr_o,
  input wire logic          nvm_rd_o,
  input wire logic [AW-1:0] nvm_addr_o,
  input wire logic          nvm_ack_i,
  input wire logic          restore_req_i,
  input wire logic          busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Host decodes watched by several properties
  wire commit_wr = reg_wr_i && reg_addr_i == COMMIT_ADDR && reg_wdata_i[COMMIT_BIT];
  wire list_rd   = reg_rd_i && reg_addr_i >= LIST_BASE && reg_addr_i <= LIST_LAST;
  wire nvm_req   = nvm_wr_o || nvm_rd_o;

  a_commit_pulse: assert property (commit_wr |=> commit_o)
    else $error("commit pulse missing after host write");
  a_commit_once: assert property (commit_o && !commit_wr |=> !commit_o)
    else $error("commit pulse longer than one cycle");
  a_commit_cause: assert property (commit_o |-> $past(commit_wr || busy_o))
    else $error("commit pulse without a cause");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(reg_wr_i || restore_req_i))
    else $error("walk began without a request");
  a_req_held: assert property (nvm_req && !nvm_ack_i |=> nvm_req && $stable(nvm_addr_o))
    else $error("nvm request dropped before ack");
  a_idle_quiet: assert property (!busy_o |-> !(nvm_req || rs_rd_o || rs_wr_o))
    else $error("traffic while not busy");
  a_list_rdzero: assert property (list_rd |=> reg_rdata_o == 8'h00)
    else $error("list read not zero");
  a_nvm_excl: assert property (!(nvm_wr_o && nvm_rd_o))
    else $error("nvm read and write together");

  c_apply: cover property (commit_o && busy_o);
  c_store: cover property (nvm_wr_o && nvm_ack_i);
  c_restore: cover property (rs_wr_o);
endmodule : nvm_loader_chk

bind nvm_loader nvm_loader_chk u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .commit_o(commit_o), .rs_rd_o(rs_rd_o), .rs_wr_o(rs_wr_o), .nvm_wr_o(nvm_wr_o), .nvm_rd_o(nvm_rd_o),
  .nvm_addr_o(nvm_addr_o), .nvm_ack_i(nvm_ack_i), .restore_req_i(restore_req_i), .busy_o(busy_o));

// File: verification/nvm_loader_tb.sv
// Self-checking bench for the command-list loader
`timescale 1ns/100ps
module nvm_loader_tb;
  import nvm_loader_pkg::*;
  logic mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, restore_req_i = 1'b0;
  logic bad = 1'b0, mon_en = 1'b1;
  logic [AW-1:0] reg_addr_i = '0, rs_addr_o, nvm_addr_o, base;
  logic [DW-1:0] reg_wdata_i = '0, reg_rdata_o, rs_wdata_o, rs_rdata_i, nvm_wdata_o, nvm_rdata_i;
  logic commit_o, rs_rd_o, rs_wr_o, nvm_wr_o, nvm_rd_o, nvm_ack_i, nvm_err_i, busy_o;
  logic [1:0] lat = 2'd0;
  logic [31:0] seed = 32'h5441;
  logic [23:0] expq[$];
  int n_fail = 0;
  int n_checks = 0;

  nvm_loader #(.GAP(4)) DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .commit_o(commit_o),
    .rs_rd_o(rs_rd_o), .rs_wr_o(rs_wr_o), .rs_addr_o(rs_addr_o), .rs_wdata_o(rs_wdata_o), .rs_rdata_i(rs_rdata_i),
    .nvm_wr_o(nvm_wr_o), .nvm_rd_o(nvm_rd_o), .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
    .nvm_rdata_i(nvm_rdata_i), .nvm_ack_i(nvm_ack_i), .nvm_err_i(nvm_err_i), .restore_req_i(restore_req_i),
    .busy_o(busy_o));
  nvm_partner u_nvm (.mclk_i(mclk_i), .rs_addr_i(rs_addr_o), .rs_rdata_o(rs_rdata_i), .wr_i(nvm_wr_o),
    .rd_i(nvm_rd_o), .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .rdata_o(nvm_rdata_i), .ack_o(nvm_ack_i),
    .err_o(nvm_err_i), .lat_i(lat), .bad_i(bad));

  initial forever #2 mclk_i = ~mclk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] hash(input logic [AW-1:0] a);
    return a[7:0] ^ a[11:4];
  endfunction : hash

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(negedge mclk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    check({16'h0, reg_rdata_o}, {16'h0, e});
  endtask : rd

  // Bounded wait for the walk flag to reach a level
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 30000 && busy_o !== lvl; i++)
      @(negedge mclk_i);
    if (busy_o !== lvl)
    begin
      n_fail++;
      $display("ERROR %0t: busy wait timed out", $time);
      tally_and_finish();
    end
  endtask : wait_busy

  // Each visible result consumes the oldest note
  always @(posedge mclk_i)
    if (resetn_i && mon_en && (commit_o || rs_wr_o || (nvm_wr_o && nvm_ack_i)))
      check(commit_o ? 24'h100000 : rs_wr_o ? {4'h3, rs_addr_o, rs_wdata_o} : {12'h200, nvm_wdata_o},
            expq.size() > 0 ? expq.pop_front() : 24'hffffff);

  initial
  begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    resetn_i = 1'b1;
    expq.push_back(24'h100000);
    wr(COMMIT_ADDR, 8'h01);
    rd(COMMIT_ADDR, 8'h00);
    $display("test commit done");
    // untouched default list stores every register, then applies
    rd(LIST_BASE, 8'h00);
    wr(NVM_CTRL_ADDR, 8'h01);
    for (int a = 0; a < 4096; a++)
      expq.push_back({12'h200, hash(12'(a))});
    expq.push_back(24'h100000);
    wr(STORE_TRIG_ADDR, 8'h01);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(24'(expq.size()), 24'h0);
    rd(XFER_ERR_ADDR, 8'h00);
    repeat (8) @(negedge mclk_i);
    $display("test default list done");
    for (int k = 0; k < 3; k++)
    begin
      seed = xs(seed);
      lat = seed[1:0];
      base = {4'h1, seed[15:8]};
      // two-byte entry, apply, end; end in last byte
      wr(LIST_BASE, 8'h01);
      wr(LIST_BASE + 12'h1, {4'h0, base[11:8]});
      wr(LIST_BASE + 12'h2, base[7:0]);
      wr(LIST_BASE + 12'h3, {1'b1, OP_APPLY_STAGED});
      wr(LIST_BASE + 12'h4, {1'b1, OP_END_OF_DATA});
      wr(LIST_LAST, {1'b1, OP_END_OF_DATA});
      wr(NVM_CTRL_ADDR, 8'h01);
      expq.push_back({12'h200, hash(base)});
      expq.push_back({12'h200, hash(base + 12'h1)});
      expq.push_back(24'h100000);
      wr(STORE_TRIG_ADDR, 8'h01);
      wait_busy(1'b1);
      rd(STORE_TRIG_ADDR, 8'h01);
      rd(XFER_STAT_ADDR, 8'h01);
      wait_busy(1'b0);
      rd(XFER_STAT_ADDR, 8'h00);
      rd(STORE_TRIG_ADDR, 8'h00);
      rd(XFER_ERR_ADDR, 8'h00);
      // host keeps the gap before the next transfer
      repeat (8) @(negedge mclk_i);
      expq.push_back({4'h3, base, hash(base)});
      expq.push_back({4'h3, base + 12'h1, hash(base + 12'h1)});
      expq.push_back(24'h100000);
      wr(NVM_CTRL_ADDR, 8'h02);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (8) @(negedge mclk_i);
      $display("test store and restore %0d done", k);
    end
    // bad data on restore from the pin
    mon_en = 1'b0;
    bad = 1'b1;
    @(negedge mclk_i);
    restore_req_i = 1'b1;
    @(negedge mclk_i);
    restore_req_i = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(XFER_ERR_ADDR, 8'h01);
    bad = 1'b0;
    mon_en = 1'b1;
    repeat (8) @(negedge mclk_i);
    $display("test error done");
    // unknown opcode ends the walk as bad data
    wr(LIST_BASE, 8'h85);
    wr(NVM_CTRL_ADDR, 8'h02);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(XFER_ERR_ADDR, 8'h01);
    repeat (8) @(negedge mclk_i);
    $display("test bad opcode done");
    // store refused while writes are locked
    wr(NVM_CTRL_ADDR, 8'h00);
    wr(STORE_TRIG_ADDR, 8'h01);
    repeat (6) @(negedge mclk_i);
    check({23'h0, busy_o}, 24'h0);
    check(24'(expq.size()), 24'h0);
    $display("test refusal done");
    tally_and_finish();
  end
endmodule : nvm_loader_tb

// File: verification/nvm_partner.sv
// Behavioural nvm array and register space beside the loader
`timescale 1ns/100ps
module nvm_partner
  import nvm_loader_pkg::*;
(
  // Clock
  input  wire logic          mclk_i,
  // Register space side
  input  wire logic [AW-1:0] rs_addr_i,
  output logic      [DW-1:0] rs_rdata_o,
  // Nvm side
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o,
  output logic               ack_o,
  output logic               err_o,
  // Knobs: answer delay and bad data
  input  wire logic [1:0]    lat_i,
  input  wire logic          bad_i
);
  logic [DW-1:0] mem [0:4095];
  logic [1:0]    wait_q = 2'd0;
  initial ack_o = 1'b0;
  initial rdata_o = 8'h00;
  // Register contents are a fixed hash of the address
  assign rs_rdata_o = rs_addr_i[7:0] ^ rs_addr_i[11:4];
  assign err_o = ack_o & bad_i;
  // Ack after lat_i idle cycles; data inverts when not answering
  always @(posedge mclk_i)
  begin
    if ((wr_i || rd_i) && !ack_o && wait_q == 2'd0)
    begin
      ack_o <= 1'b1;
      rdata_o <= mem[addr_i];
      if (wr_i)
        mem[addr_i] <= wdata_i;
    end
    else
    begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_q <= ((wr_i || rd_i) && !ack_o) ? wait_q - 2'd1 : lat_i;
    end
  end
endmodule : nvm_partner
